// ===== logic/tw_consts.vh
`ifndef TW_CONSTS_VH
`define TW_CONSTS_VH
`define TW_SYS_HZ 10000000
`define TW_BIT_HZ 100000
`define TW_QPB 4
`define TW_DW 8
`define TW_TXW 9
`define TW_FAW 4
`define TW_CMD_BIT 8
`define TW_LAST_BIT 4'h7
`define TW_ACK_BC 4'h8
`define TW_TEN_HDR 5'h1E
`define TW_GC_ADDR 8'h00
`define TW_IRQ_W 11
`define TW_I_RX_OVER 0
`define TW_I_TX_OVER 1
`define TW_I_RX_THR 2
`define TW_I_TX_EMPTY 3
`define TW_I_TX_FULL 4
`define TW_I_RD_REQ 5
`define TW_I_TX_ABRT 6
`define TW_I_ACK_ERR 7
`define TW_I_STOP 8
`define TW_I_START 9
`define TW_I_GEN_CALL 10
`define TW_HW_ONLY 11'h01C
`endif

// ===== logic/tw_fifo.v
`timescale 1ns/1ps
`include "tw_consts.vh"
module tw_fifo #(
  parameter W = `TW_DW,
  parameter AW = `TW_FAW
) (
  input wire clk_in, // system clock
  input wire rst_n_in, // sync reset, low
  input wire wr_in, // push strobe
  input wire [W-1:0] wdata_in, // push data
  input wire rd_in, // pop strobe
  output wire [W-1:0] head_out, // oldest entry
  output wire [AW:0] cnt_out, // fill level
  output wire empty_out, // no entries
  output wire full_out // no room
);
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire do_wr = wr_in & (cnt_r != DEPTH);
  wire do_rd = rd_in & (cnt_r != {(AW+1){1'b0}});
  assign head_out = mem[rp_r];
  assign cnt_out = cnt_r;
  assign empty_out = (cnt_r == {(AW+1){1'b0}});
  assign full_out = (cnt_r == DEPTH);
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr)
        wp_r <= wp_r + 1'b1;
      if (do_rd)
        rp_r <= rp_r + 1'b1;
      if (do_wr & !do_rd)
        cnt_r <= cnt_r + 1'b1;
      else if (do_rd & !do_wr)
        cnt_r <= cnt_r - 1'b1;
    end
  end
  always @(posedge clk_in) begin
    if (do_wr)
      mem[wp_r] <= wdata_in;
  end
endmodule // tw_fifo

// ===== logic/tw_irq.v
`timescale 1ns/1ps
`include "tw_consts.vh"
module tw_irq (
  input wire clk_in, // system clock
  input wire rst_n_in, // sync reset, low
  input wire [`TW_IRQ_W-1:0] set_in, // event pulses
  input wire [`TW_IRQ_W-1:0] lvl_in, // hardware-held levels
  input wire [`TW_IRQ_W-1:0] clr_in, // clear pulses
  input wire [`TW_IRQ_W-1:0] mask_in, // 1 enables source
  output reg [`TW_IRQ_W-1:0] raw_out, // raw flags
  output reg [`TW_IRQ_W-1:0] mis_out, // masked flags
  output reg irq_out // combined interrupt
);
  wire [`TW_IRQ_W-1:0] hw = `TW_HW_ONLY;
  // set beats clear; hardware-only bits follow their level
  wire [`TW_IRQ_W-1:0] raw_nxt = (hw & lvl_in) |
    (~hw & ((raw_out & ~clr_in) | set_in));
  wire [`TW_IRQ_W-1:0] mis_nxt = raw_nxt & mask_in;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      raw_out <= {`TW_IRQ_W{1'b0}};
      mis_out <= {`TW_IRQ_W{1'b0}};
      irq_out <= 1'b0;
    end else begin
      raw_out <= raw_nxt;
      mis_out <= mis_nxt;
      irq_out <= |mis_nxt;
    end
  end
endmodule // tw_irq

// ===== logic/tw_ctrl.v
`timescale 1ns/1ps
`include "tw_consts.vh"
module tw_ctrl (
  input wire CLK_SYS_IN, // system clock
  input wire RST_N_IN, // sync reset, low
  input wire ENABLE_IN, // controller enable
  input wire CHAN_SEL_IN, // pin pair select
  input wire MASTER_EN_IN, // master role on
  input wire SLAVE_EN_IN, // slave role on
  input wire SLV_TEN_IN, // slave 10-bit mode
  input wire MST_TEN_IN, // master 10-bit mode
  input wire [9:0] SLV_ADDR_IN, // own slave address
  input wire [9:0] TGT_ADDR_IN, // master target address
  input wire TX_WR_IN, // queue tx entry
  input wire [8:0] TX_DATA_IN, // cmd bit and byte
  input wire RX_RD_IN, // pop rx byte
  input wire [3:0] RX_TL_IN, // rx threshold
  input wire [3:0] TX_TL_IN, // tx threshold
  input wire [10:0] IRQ_MASK_IN, // irq enables
  input wire [10:0] IRQ_CLR_IN, // irq clear pulses
  output reg [7:0] RX_DATA_OUT, // popped rx byte
  output wire [4:0] RX_LEVEL_OUT, // rx fill level
  output wire [4:0] TX_LEVEL_OUT, // tx fill level
  output wire [10:0] RAW_STATUS_OUT, // raw flags
  output wire [10:0] MASKED_STATUS_OUT, // masked flags
  output wire IRQ_OUT, // combined interrupt
  output reg BUS_BUSY_OUT, // start seen, no stop
  output reg MST_ACTIVE_OUT, // master in transfer
  output reg SLV_ACTIVE_OUT, // slave addressed
  input wire DATA_PIN_CHANNEL_ZERO_IN, // ch0 data level
  output wire DATA_PIN_CHANNEL_ZERO_OUT, // ch0 data drive
  output reg DATA_PIN_CHANNEL_ZERO_OE_OUT, // ch0 data enable
  input wire CLOCK_PIN_CHANNEL_ZERO_IN, // ch0 clock level
  output wire CLOCK_PIN_CHANNEL_ZERO_OUT, // ch0 clock drive
  output reg CLOCK_PIN_CHANNEL_ZERO_OE_OUT, // ch0 clock enable
  input wire DATA_PIN_CHANNEL_ONE_IN, // ch1 data level
  output wire DATA_PIN_CHANNEL_ONE_OUT, // ch1 data drive
  output reg DATA_PIN_CHANNEL_ONE_OE_OUT, // ch1 data enable
  input wire CLOCK_PIN_CHANNEL_ONE_IN, // ch1 clock level
  output wire CLOCK_PIN_CHANNEL_ONE_OUT, // ch1 clock drive
  output reg CLOCK_PIN_CHANNEL_ONE_OE_OUT // ch1 clock enable
);
  localparam [31:0] QCYC = `TW_SYS_HZ / (`TW_BIT_HZ * `TW_QPB);
  localparam [7:0] QLAST = QCYC[7:0] - 8'h01;
  localparam [1:0] MS_IDLE = 2'h0;
  localparam [1:0] MS_START = 2'h1;
  localparam [1:0] MS_BYTE = 2'h2;
  localparam [1:0] MS_STOP = 2'h3;
  localparam [1:0] STG_HDR1 = 2'h0;
  localparam [1:0] STG_HDR2 = 2'h1;
  localparam [1:0] STG_DATA = 2'h2;
  localparam [2:0] SS_IDLE = 3'h0;
  localparam [2:0] SS_ADDR = 3'h1;
  localparam [2:0] SS_ACK = 3'h2;
  localparam [2:0] SS_RX = 3'h3;
  localparam [2:0] SS_TX = 3'h4;
  localparam [2:0] SS_TXACK = 3'h5;
  localparam [2:0] SS_WAIT = 3'h6;

  function [7:0] hdr_byte;
    input ten;
    input [9:0] addr;
    input rd;
    begin
      if (ten)
        hdr_byte = {`TW_TEN_HDR, addr[9:8], rd};
      else
        hdr_byte = {addr[6:0], rd};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin sampling, bit-rate divider, bus conditions
  reg [3:0] pin_m_r;
  reg [3:0] pin_s_r;
  reg sda_p_r;
  reg scl_p_r;
  reg [7:0] q_cnt_r;
  reg tick_r;
  reg pin_lo_r;
  wire sda_s = CHAN_SEL_IN ? pin_s_r[2] : pin_s_r[0];
  wire scl_s = CHAN_SEL_IN ? pin_s_r[3] : pin_s_r[1];
  wire start_det = scl_s & scl_p_r & sda_p_r & !sda_s;
  wire stop_det = scl_s & scl_p_r & !sda_p_r & sda_s;
  wire scl_rise = scl_s & !scl_p_r;
  wire scl_fall = !scl_s & scl_p_r;

  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      pin_m_r <= 4'hF;
      pin_s_r <= 4'hF;
      sda_p_r <= 1'b1;
      scl_p_r <= 1'b1;
      q_cnt_r <= 8'h00;
      tick_r <= 1'b0;
      pin_lo_r <= 1'b0;
      BUS_BUSY_OUT <= 1'b0;
    end else begin
      pin_m_r <= {CLOCK_PIN_CHANNEL_ONE_IN, DATA_PIN_CHANNEL_ONE_IN,
                  CLOCK_PIN_CHANNEL_ZERO_IN, DATA_PIN_CHANNEL_ZERO_IN};
      pin_s_r <= pin_m_r;
      sda_p_r <= sda_s;
      scl_p_r <= scl_s;
      pin_lo_r <= 1'b0;
      if (q_cnt_r == QLAST) begin
        q_cnt_r <= 8'h00;
        tick_r <= 1'b1;
      end else begin
        q_cnt_r <= q_cnt_r + 8'h01;
        tick_r <= 1'b0;
      end
      if (start_det)
        BUS_BUSY_OUT <= 1'b1;
      else if (stop_det)
        BUS_BUSY_OUT <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFOs
  reg m_pop_r;
  reg s_pop_r;
  reg m_push_r;
  reg s_push_r;
  reg [7:0] m_pdat_r;
  reg [7:0] s_pdat_r;
  wire [8:0] tx_head;
  wire [7:0] rx_head;
  wire tx_empty;
  wire tx_full;
  wire rx_empty;
  wire rx_full;
  wire rx_push = m_push_r | s_push_r;
  wire [7:0] rx_wdata = m_push_r ? m_pdat_r : s_pdat_r;

  tw_fifo #(.W(`TW_TXW), .AW(`TW_FAW)) u_txf (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .wr_in(TX_WR_IN),
    .wdata_in(TX_DATA_IN),
    .rd_in(m_pop_r | s_pop_r),
    .head_out(tx_head),
    .cnt_out(TX_LEVEL_OUT),
    .empty_out(tx_empty),
    .full_out(tx_full)
  );

  tw_fifo #(.W(`TW_DW), .AW(`TW_FAW)) u_rxf (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .wr_in(rx_push),
    .wdata_in(rx_wdata),
    .rd_in(RX_RD_IN),
    .head_out(rx_head),
    .cnt_out(RX_LEVEL_OUT),
    .empty_out(rx_empty),
    .full_out(rx_full)
  );

  //////////////////////////////////////////////////////////////////////////
  // master controller
  reg [1:0] m_st_r;
  reg [1:0] m_ph_r;
  reg [1:0] m_stg_r;
  reg [3:0] m_bc_r;
  reg [7:0] m_sh_r;
  reg m_rd_r;
  reg m_tenrs_r;
  reg m_dly_r;
  reg m_sda_low_r;
  reg m_scl_low_r;
  reg m_abrt_r;
  reg m_nack_r;
  reg [2:0] s_st_r;
  wire m_tx = (m_stg_r != STG_DATA) | !m_rd_r;

  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN || !ENABLE_IN) begin
      m_st_r <= MS_IDLE;
      m_ph_r <= 2'h0;
      m_stg_r <= STG_HDR1;
      m_bc_r <= 4'h0;
      m_sh_r <= 8'h00;
      m_rd_r <= 1'b0;
      m_tenrs_r <= 1'b0;
      m_dly_r <= 1'b0;
      m_sda_low_r <= 1'b0;
      m_scl_low_r <= 1'b0;
      m_pop_r <= 1'b0;
      m_push_r <= 1'b0;
      m_pdat_r <= 8'h00;
      m_abrt_r <= 1'b0;
      m_nack_r <= 1'b0;
    end else begin
      m_pop_r <= 1'b0;
      m_push_r <= 1'b0;
      m_abrt_r <= 1'b0;
      m_nack_r <= 1'b0;
      if (tick_r) begin
        case (m_st_r)
          MS_IDLE: begin
            // only start on an idle bus, and not while being addressed
            if (MASTER_EN_IN & !tx_empty & !BUS_BUSY_OUT &
                (s_st_r == SS_IDLE)) begin
              m_rd_r <= tx_head[`TW_CMD_BIT];
              m_tenrs_r <= 1'b0;
              m_stg_r <= STG_HDR1;
              m_sh_r <= hdr_byte(MST_TEN_IN, TGT_ADDR_IN,
                tx_head[`TW_CMD_BIT] & !MST_TEN_IN);
              m_st_r <= MS_START;
              m_ph_r <= 2'h1;
              m_dly_r <= 1'b0;
            end
          end
          MS_START: begin
            case (m_ph_r)
              2'h0: m_scl_low_r <= 1'b1;
              2'h1: m_sda_low_r <= 1'b0;
              2'h2: m_scl_low_r <= 1'b0;
              default: begin
                if (scl_s & !m_dly_r)
                  m_dly_r <= 1'b1;
                else if (scl_s) begin
                  m_sda_low_r <= 1'b1;
                  m_dly_r <= 1'b0;
                  m_st_r <= MS_BYTE;
                  m_bc_r <= 4'h0;
                end
              end
            endcase
            if (m_ph_r != 2'h3)
              m_ph_r <= m_ph_r + 2'h1;
            else if (scl_s & m_dly_r)
              m_ph_r <= 2'h0;
          end
          MS_BYTE: begin
            case (m_ph_r)
              2'h0: m_scl_low_r <= 1'b1;
              2'h1: begin
                if (m_bc_r != `TW_ACK_BC)
                  m_sda_low_r <= m_tx & !m_sh_r[7];
                else // ack a read only if another read is queued
                  m_sda_low_r <= !m_tx & !tx_empty &
                    tx_head[`TW_CMD_BIT];
              end
              2'h2: m_scl_low_r <= 1'b0;
              default: begin
                if (scl_s && m_bc_r != `TW_ACK_BC) begin
                  if (m_tx & m_sh_r[7] & !sda_s) begin
                    m_abrt_r <= 1'b1;
                    m_sda_low_r <= 1'b0;
                    m_scl_low_r <= 1'b0;
                    m_st_r <= MS_IDLE;
                  end else begin
                    m_sh_r <= {m_sh_r[6:0], sda_s};
                    m_bc_r <= m_bc_r + 4'h1;
                  end
                end else if (scl_s) begin
                  m_bc_r <= 4'h0;
                  if (m_tx & sda_s) begin
                    m_nack_r <= 1'b1;
                    m_abrt_r <= 1'b1;
                    m_st_r <= MS_STOP;
                  end else if (m_stg_r == STG_HDR1 & MST_TEN_IN &
                               !m_tenrs_r) begin
                    m_stg_r <= STG_HDR2;
                    m_sh_r <= TGT_ADDR_IN[7:0];
                  end else if (m_stg_r == STG_HDR2 & m_rd_r) begin
                    m_tenrs_r <= 1'b1;
                    m_stg_r <= STG_HDR1;
                    m_sh_r <= hdr_byte(1'b1, TGT_ADDR_IN, 1'b1);
                    m_st_r <= MS_START;
                  end else begin
                    if (m_stg_r == STG_DATA & m_rd_r) begin
                      m_push_r <= 1'b1;
                      m_pdat_r <= m_sh_r;
                    end
                    if (tx_empty)
                      m_st_r <= MS_STOP;
                    else if (tx_head[`TW_CMD_BIT] != m_rd_r) begin
                      m_rd_r <= tx_head[`TW_CMD_BIT];
                      m_tenrs_r <= 1'b0;
                      m_stg_r <= STG_HDR1;
                      m_sh_r <= hdr_byte(MST_TEN_IN, TGT_ADDR_IN,
                        tx_head[`TW_CMD_BIT] & !MST_TEN_IN);
                      m_st_r <= MS_START;
                    end else begin
                      m_stg_r <= STG_DATA;
                      m_pop_r <= 1'b1;
                      m_sh_r <= tx_head[7:0];
                    end
                  end
                end
              end
            endcase
            if (m_ph_r != 2'h3 || scl_s)
              m_ph_r <= m_ph_r + 2'h1;
          end
          MS_STOP: begin
            case (m_ph_r)
              2'h0: m_scl_low_r <= 1'b1;
              2'h1: m_sda_low_r <= 1'b1;
              2'h2: m_scl_low_r <= 1'b0;
              default: begin
                if (scl_s & !m_dly_r)
                  m_dly_r <= 1'b1;
                else if (scl_s) begin
                  m_sda_low_r <= 1'b0;
                  m_dly_r <= 1'b0;
                  m_st_r <= MS_IDLE;
                end
              end
            endcase
            if (m_ph_r != 2'h3)
              m_ph_r <= m_ph_r + 2'h1;
            else if (scl_s & m_dly_r)
              m_ph_r <= 2'h0;
          end
          default: m_st_r <= MS_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // slave controller
  reg [2:0] s_go_r;
  reg [3:0] s_bc_r;
  reg [7:0] s_sh_r;
  reg s_hb_r;
  reg s_ten_ok_r;
  reg s_mnack_r;
  reg s_sda_low_r;
  reg s_scl_low_r;
  reg s_rdreq_r;
  reg s_gc_r;

  task s_load;
    begin
      if (tx_empty) begin
        s_scl_low_r <= 1'b1;
        s_rdreq_r <= 1'b1;
        s_st_r <= SS_WAIT;
      end else begin
        s_pop_r <= 1'b1;
        s_sh_r <= tx_head[7:0];
        s_sda_low_r <= !tx_head[7];
        s_bc_r <= 4'h0;
        s_st_r <= SS_TX;
      end
    end
  endtask

  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN || !ENABLE_IN || !SLAVE_EN_IN) begin
      s_st_r <= SS_IDLE;
      s_go_r <= SS_IDLE;
      s_bc_r <= 4'h0;
      s_sh_r <= 8'h00;
      s_hb_r <= 1'b0;
      s_ten_ok_r <= 1'b0;
      s_mnack_r <= 1'b0;
      s_sda_low_r <= 1'b0;
      s_scl_low_r <= 1'b0;
      s_pop_r <= 1'b0;
      s_push_r <= 1'b0;
      s_pdat_r <= 8'h00;
      s_rdreq_r <= 1'b0;
      s_gc_r <= 1'b0;
    end else begin
      s_pop_r <= 1'b0;
      s_push_r <= 1'b0;
      s_rdreq_r <= 1'b0;
      s_gc_r <= 1'b0;
      if (start_det) begin
        s_st_r <= SS_ADDR;
        s_bc_r <= 4'h0;
        s_hb_r <= 1'b0;
        s_sda_low_r <= 1'b0;
        s_scl_low_r <= 1'b0;
      end else if (stop_det) begin
        s_st_r <= SS_IDLE;
        s_ten_ok_r <= 1'b0;
        s_sda_low_r <= 1'b0;
        s_scl_low_r <= 1'b0;
      end else begin
        case (s_st_r)
          SS_ADDR, SS_RX: begin
            if (scl_rise) begin
              s_sh_r <= {s_sh_r[6:0], sda_s};
              s_bc_r <= s_bc_r + 4'h1;
            end else if (scl_fall && s_bc_r == `TW_ACK_BC) begin
              s_bc_r <= 4'h0;
              s_sda_low_r <= 1'b1;
              s_st_r <= SS_ACK;
              s_go_r <= SS_RX;
              if (s_st_r == SS_RX) begin
                s_push_r <= 1'b1;
                s_pdat_r <= s_sh_r;
              end else if (s_sh_r == `TW_GC_ADDR)
                s_gc_r <= 1'b1;
              else if (!SLV_TEN_IN) begin
                if (s_sh_r[7:1] == SLV_ADDR_IN[6:0])
                  s_go_r <= s_sh_r[0] ? SS_TX : SS_RX;
                else begin
                  s_sda_low_r <= 1'b0;
                  s_st_r <= SS_IDLE;
                end
              end else if (s_hb_r) begin
                if (s_sh_r == SLV_ADDR_IN[7:0])
                  s_ten_ok_r <= 1'b1;
                else begin
                  s_sda_low_r <= 1'b0;
                  s_st_r <= SS_IDLE;
                end
              end else if (s_sh_r[7:1] ==
                           {`TW_TEN_HDR, SLV_ADDR_IN[9:8]} &&
                           (!s_sh_r[0] || s_ten_ok_r)) begin
                s_hb_r <= !s_sh_r[0];
                s_go_r <= s_sh_r[0] ? SS_TX : SS_ADDR;
              end else begin
                s_sda_low_r <= 1'b0;
                s_st_r <= SS_IDLE;
              end
            end
          end
          SS_ACK: begin
            if (scl_fall) begin
              s_sda_low_r <= 1'b0;
              s_bc_r <= 4'h0;
              if (s_go_r == SS_TX)
                s_load;
              else
                s_st_r <= s_go_r;
            end
          end
          SS_TX: begin
            if (s_scl_low_r & tick_r)
              s_scl_low_r <= 1'b0;
            if (scl_fall && s_bc_r == `TW_LAST_BIT) begin
              s_sda_low_r <= 1'b0;
              s_st_r <= SS_TXACK;
            end else if (scl_fall) begin
              s_sh_r <= {s_sh_r[6:0], 1'b0};
              s_sda_low_r <= !s_sh_r[6];
              s_bc_r <= s_bc_r + 4'h1;
            end
          end
          SS_TXACK: begin
            if (scl_rise)
              s_mnack_r <= sda_s;
            else if (scl_fall & !s_mnack_r)
              s_load;
            else if (scl_fall)
              s_st_r <= SS_IDLE;
          end
          SS_WAIT: begin
            if (!tx_empty)
              s_load;
          end
          default: s_st_r <= SS_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt sources
  reg [10:0] irq_set;
  reg [10:0] irq_lvl;
  always @* begin
    irq_set = {`TW_IRQ_W{1'b0}};
    irq_lvl = {`TW_IRQ_W{1'b0}};
    irq_set[`TW_I_RX_OVER] = rx_push & rx_full;
    irq_set[`TW_I_TX_OVER] = TX_WR_IN & tx_full;
    irq_set[`TW_I_RD_REQ] = s_rdreq_r;
    irq_set[`TW_I_TX_ABRT] = m_abrt_r;
    irq_set[`TW_I_ACK_ERR] = m_nack_r;
    irq_set[`TW_I_STOP] = stop_det;
    irq_set[`TW_I_START] = start_det;
    irq_set[`TW_I_GEN_CALL] = s_gc_r;
    irq_lvl[`TW_I_RX_THR] = RX_LEVEL_OUT > {1'b0, RX_TL_IN};
    irq_lvl[`TW_I_TX_EMPTY] = TX_LEVEL_OUT <= {1'b0, TX_TL_IN};
    irq_lvl[`TW_I_TX_FULL] = tx_full;
  end

  tw_irq u_irq (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .set_in(irq_set),
    .lvl_in(irq_lvl),
    .clr_in(IRQ_CLR_IN),
    .mask_in(IRQ_MASK_IN),
    .raw_out(RAW_STATUS_OUT),
    .mis_out(MASKED_STATUS_OUT),
    .irq_out(IRQ_OUT)
  );

  //////////////////////////////////////////////////////////////////////////
  // pin drive and status
  wire sda_low = m_sda_low_r | s_sda_low_r;
  wire scl_low = m_scl_low_r | s_scl_low_r;
  assign DATA_PIN_CHANNEL_ZERO_OUT = pin_lo_r;
  assign CLOCK_PIN_CHANNEL_ZERO_OUT = pin_lo_r;
  assign DATA_PIN_CHANNEL_ONE_OUT = pin_lo_r;
  assign CLOCK_PIN_CHANNEL_ONE_OUT = pin_lo_r;
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      DATA_PIN_CHANNEL_ZERO_OE_OUT <= 1'b0;
      CLOCK_PIN_CHANNEL_ZERO_OE_OUT <= 1'b0;
      DATA_PIN_CHANNEL_ONE_OE_OUT <= 1'b0;
      CLOCK_PIN_CHANNEL_ONE_OE_OUT <= 1'b0;
      MST_ACTIVE_OUT <= 1'b0;
      SLV_ACTIVE_OUT <= 1'b0;
      RX_DATA_OUT <= 8'h00;
    end else begin
      DATA_PIN_CHANNEL_ZERO_OE_OUT <= !CHAN_SEL_IN & sda_low;
      CLOCK_PIN_CHANNEL_ZERO_OE_OUT <= !CHAN_SEL_IN & scl_low;
      DATA_PIN_CHANNEL_ONE_OE_OUT <= CHAN_SEL_IN & sda_low;
      CLOCK_PIN_CHANNEL_ONE_OE_OUT <= CHAN_SEL_IN & scl_low;
      MST_ACTIVE_OUT <= (m_st_r != MS_IDLE);
      SLV_ACTIVE_OUT <= (s_st_r != SS_IDLE) & (s_st_r != SS_ADDR);
      if (RX_RD_IN & !rx_empty)
        RX_DATA_OUT <= rx_head;
    end
  end
endmodule // tw_ctrl

// ===== verif/tw_ctrl_assertions.sv
`timescale 1ns/1ps
module tw_chk (
  input wire CLK_SYS_IN, // clk
  input wire RST_N_IN, // rst
  input wire ENABLE_IN, // en
  input wire CHAN_SEL_IN, // pair
  input wire [10:0] IRQ_MASK_IN, // mask
  input wire [4:0] TX_LEVEL_OUT, // fill
  input wire [10:0] MASKED_STATUS_OUT, // masked
  input wire IRQ_OUT, // irq
  input wire DATA_PIN_CHANNEL_ZERO_OE_OUT, // oe
  input wire CLOCK_PIN_CHANNEL_ZERO_OE_OUT, // oe
  input wire DATA_PIN_CHANNEL_ONE_OE_OUT, // oe
  input wire CLOCK_PIN_CHANNEL_ONE_OE_OUT // oe
);
  wire oe0 = DATA_PIN_CHANNEL_ZERO_OE_OUT | CLOCK_PIN_CHANNEL_ZERO_OE_OUT;
  wire oe1 = DATA_PIN_CHANNEL_ONE_OE_OUT | CLOCK_PIN_CHANNEL_ONE_OE_OUT;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_on; (|MASKED_STATUS_OUT)[*2]; endsequence
  sequence s_off; (MASKED_STATUS_OUT == 11'h000)[*2]; endsequence
  AST_IRQ_ON: assert property (s_on |-> IRQ_OUT)
    else $error("irq low");
  AST_IRQ_OFF: assert property (s_off |-> !IRQ_OUT)
    else $error("irq high");
  AST_MASK: assert property (
    (~|IRQ_MASK_IN)[*2] |-> ~|MASKED_STATUS_OUT) else $error("mask");
  AST_RST: assert property (
    $past(!RST_N_IN) |-> !IRQ_OUT && !oe0 && !oe1) else $error("rst");
  AST_DIS: assert property ((!ENABLE_IN)[*3] |-> !oe0 && !oe1)
    else $error("off");
  AST_CH0: assert property (CHAN_SEL_IN[*3] |-> !oe0)
    else $error("ch0");
  AST_CH1: assert property ((!CHAN_SEL_IN)[*3] |-> !oe1)
    else $error("ch1");
  AST_LVL: assert property (TX_LEVEL_OUT <= 5'h10)
    else $error("level");
endmodule // tw_chk
bind tw_ctrl tw_chk u_chk (
  .CLK_SYS_IN(CLK_SYS_IN),
  .RST_N_IN(RST_N_IN),
  .ENABLE_IN(ENABLE_IN),
  .CHAN_SEL_IN(CHAN_SEL_IN),
  .IRQ_MASK_IN(IRQ_MASK_IN),
  .TX_LEVEL_OUT(TX_LEVEL_OUT),
  .MASKED_STATUS_OUT(MASKED_STATUS_OUT),
  .IRQ_OUT(IRQ_OUT),
  .DATA_PIN_CHANNEL_ZERO_OE_OUT(DATA_PIN_CHANNEL_ZERO_OE_OUT),
  .CLOCK_PIN_CHANNEL_ZERO_OE_OUT(CLOCK_PIN_CHANNEL_ZERO_OE_OUT),
  .DATA_PIN_CHANNEL_ONE_OE_OUT(DATA_PIN_CHANNEL_ONE_OE_OUT),
  .CLOCK_PIN_CHANNEL_ONE_OE_OUT(CLOCK_PIN_CHANNEL_ONE_OE_OUT)
);

// ===== verif/tw_peer.sv
`timescale 1ns/1ps
module tw_peer (
  input wire scl_in, // bus clock
  input wire sda_in, // bus data
  output logic sda_oe_out // pulls data low
);
  int n = 0;
  logic [7:0] sh = 8'h00;
  logic [7:0] got[$];
  initial sda_oe_out = 1'b0;
  always @(negedge sda_in) if (scl_in) n = -1;
  always @(posedge sda_in) if (scl_in) sda_oe_out = 1'b0;
  always @(posedge scl_in) if (n >= 0 && n < 8) sh = {sh[6:0], sda_in};
  always @(negedge scl_in) begin
    n = n + 1;
    sda_oe_out = (n == 8); // ack every byte
    if (n == 9) begin
      got.push_back(sh);
      n = 0;
    end
  end
endmodule // tw_peer

// ===== verif/two_wire_master_slave_controller_tb.sv
`timescale 1ns/1ps
module two_wire_master_slave_controller_tb;
  logic clk = 0, rst_n = 0, en = 0, sel = 0, men = 0, wr = 0, rd = 0;
  logic sen = 0, bscl = 1, bsda = 1, ack = 1;
  logic [8:0] wd = 9'h000;
  logic [10:0] msk = 11'h000, clr = 11'h000;
  logic [3:0] tl = 4'h0;
  wire [4:0] rxl, txl;
  wire [10:0] raw, mis;
  wire irq, busy, d0, c0, d1, c1, poe;
  wire sda0 = !d0 && !poe;
  wire scl0 = !c0;
  wire sda1 = !d1 && bsda;
  wire scl1 = !c1 && bscl;
  wire [7:0] rxd;
  wire [3:0] po;
  wire mact, sact;
  int error_cnt = 0, n_tests = 0;
  tw_ctrl DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ENABLE_IN(en),
    .CHAN_SEL_IN(sel), .MASTER_EN_IN(men), .SLAVE_EN_IN(sen),
    .SLV_TEN_IN(1'b0), .MST_TEN_IN(1'b0), .SLV_ADDR_IN(10'h033),
    .TGT_ADDR_IN(10'h05A), .TX_WR_IN(wr), .TX_DATA_IN(wd), .RX_RD_IN(rd),
    .RX_TL_IN(tl), .TX_TL_IN(tl), .IRQ_MASK_IN(msk), .IRQ_CLR_IN(clr),
    .RX_DATA_OUT(rxd), .RX_LEVEL_OUT(rxl), .TX_LEVEL_OUT(txl),
    .RAW_STATUS_OUT(raw), .MASKED_STATUS_OUT(mis), .IRQ_OUT(irq),
    .BUS_BUSY_OUT(busy), .MST_ACTIVE_OUT(mact), .SLV_ACTIVE_OUT(sact),
    .DATA_PIN_CHANNEL_ZERO_IN(sda0), .DATA_PIN_CHANNEL_ZERO_OUT(po[0]),
    .DATA_PIN_CHANNEL_ZERO_OE_OUT(d0), .CLOCK_PIN_CHANNEL_ZERO_IN(scl0),
    .CLOCK_PIN_CHANNEL_ZERO_OUT(po[1]), .CLOCK_PIN_CHANNEL_ZERO_OE_OUT(c0),
    .DATA_PIN_CHANNEL_ONE_IN(sda1), .DATA_PIN_CHANNEL_ONE_OUT(po[2]),
    .DATA_PIN_CHANNEL_ONE_OE_OUT(d1), .CLOCK_PIN_CHANNEL_ONE_IN(scl1),
    .CLOCK_PIN_CHANNEL_ONE_OUT(po[3]), .CLOCK_PIN_CHANNEL_ONE_OE_OUT(c1));
  tw_peer u_peer (.scl_in(scl0), .sda_in(sda0), .sda_oe_out(poe));
  initial forever #50 clk = ~clk;
  task chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task w3;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task results;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // fill tx past full with master off, then flags
  task t_fifo;
    for (int i = 0; i < 17; i++) begin
      @(posedge clk);
      sel <= 1'b1;
      wr <= 1'b1;
      wd <= 9'h0A0 + 9'(i);
    end
    @(posedge clk);
    wr <= 1'b0;
    msk <= 11'h012;
    w3;
    chk("tx level", txl, 16);
    chk("raw", raw, 11'h012);
    chk("masked", mis, 11'h012);
    chk("irq", irq, 1);
    @(posedge clk);
    clr <= 11'h012;
    rd <= 1'b1;
    @(posedge clk);
    clr <= 11'h000;
    rd <= 1'b0;
    msk <= 11'h000;
    sel <= 1'b0;
    w3;
    chk("cleared", raw, 11'h010);
    chk("irq off", irq, 0);
    chk("rx level", rxl, 0);
  endtask
  // master drains the queue to the peer on channel zero
  task t_xfer;
    @(posedge clk);
    en <= 1'b1;
    men <= 1'b1;
    repeat (200) @(posedge clk);
    #1;
    chk("mst active", mact, 1);
    for (int i = 0; i < 30000 && (txl != 0 || busy !== 1'b0); i++)
      @(posedge clk);
    w3;
    chk("bytes", u_peer.got.size(), 17);
    chk("header", u_peer.got[0], 8'hB4);
    for (int i = 1; i < 17; i++)
      chk("data", u_peer.got[i], 8'h9F + i);
    chk("start stop", raw[9:8], 2'b11);
    chk("busy", busy, 0);
    chk("lines", {d0, c0}, 0);
    chk("mst idle", mact, 0);
    chk("pin drive", po, 0);
  endtask
  // one 800 ns bus clock period from an outside master on channel one
  task sbit(input logic b);
    @(posedge clk);
    bscl <= 1'b0;
    repeat (2) @(posedge clk);
    bsda <= b;
    repeat (2) @(posedge clk);
    bscl <= 1'b1;
    repeat (3) @(posedge clk);
    #1 ack = sda1;
  endtask
  task sbyte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      sbit(v[i]);
    sbit(1'b1);
  endtask
  // outside master writes one byte to our 7-bit slave address
  task t_slave;
    @(posedge clk);
    sel <= 1'b1;
    sen <= 1'b1;
    repeat (4) @(posedge clk);
    bsda <= 1'b0;
    repeat (4) @(posedge clk);
    sbyte(8'h66);
    chk("addr ack", ack, 0);
    sbyte(8'h5C);
    chk("data ack", ack, 0);
    chk("slave on", sact, 1);
    @(posedge clk);
    bscl <= 1'b0;
    repeat (2) @(posedge clk);
    bsda <= 1'b0;
    repeat (2) @(posedge clk);
    bscl <= 1'b1;
    repeat (4) @(posedge clk);
    bsda <= 1'b1;
    w3;
    w3;
    chk("slave off", sact, 0);
    chk("rx one", rxl, 1);
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    w3;
    chk("rx byte", rxd, 8'h5C);
    chk("rx drained", rxl, 0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_fifo;
    t_xfer;
    t_slave;
    results;
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results;
  end
endmodule // two_wire_master_slave_controller_tb
